// ---- rtl/pdm_top.sv ----
// power-down mode controller top level
// -------------------------------------------------------------
// How it works
// - select bit 0: halt enters sleep
// - select bit 1: halt enters standby
// - sleep: cpu halted, peripherals run
// - standby: clocks, cpu, peripherals halted
// - clearing stop bit resumes module
// - calendar, calendar-fed timer run in standby
// - state pins: reset 11 sleep 10 standby 01 normal 00
// - wakeup low from accepted wakeup till overflow
// - reset clears primary register
// - primary bits six to three read zero
// - primary bit 2 stops timer clock
// - primary bit 1 stops calendar register clock
// - primary bit 0 stops serial clock
// - reset clears secondary register
// - secondary bit 7 stops bus clock in sleep
// - secondary bit 5 stops break unit clock
// - secondary bits 4..0 stop five clocks
// -------------------------------------------------------------
`timescale 1ns/100ps
module pdm_top (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // cpu side events
    input wire logic halt_done,
    input wire logic interrupt_req,
    input wire logic watchdog_overflow,
    input wire logic calendar_start,
    input wire logic timer_on_calendar,
    // power state
    output logic cpu_halt,
    output logic clock_generator_halt,
    output logic self_refresh,
    output logic state_pin_high_bit,
    output logic state_pin_low_bit,
    output logic wakeup_n,
    // module clock enables, high = clock runs; serial_pins_reset high = serial pins held in reset
    output logic timer_clock_en,
    output logic calendar_reg_clock_en,
    output logic calendar_count_en,
    output logic serial_clock_en,
    output logic serial_pins_reset,
    output logic peripheral_clock_en,
    output logic bus_clock_en,
    output logic break_unit_clock_en,
    output logic dma_clock_en,
    output logic dac_clock_en,
    output logic adc_clock_en,
    output logic fifo_serial_clock_en,
    output logic infrared_clock_en
);
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [7:0] ctl;
    logic [7:0] ctl2;

    pdm_regs u_regs (
        .clock(clock),
        .arst_n(arst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .standby_control(ctl),
        .standby_control_secondary(ctl2)
    );

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        pdm_pkg::pdm_state_t mode;
        logic cpu_halt;
        logic cg_halt;
        logic self_refresh;
        logic [1:0] pins;
        logic wakeup_n;
        logic [8:0] en;
        logic cal_reg_en;
        logic cal_count_en;
        logic serial_pins_reset;
        logic periph_en;
    } pdm_top_t;

    pdm_top_t s;
    pdm_top_t next_s;

    always_comb begin
        next_s = s;
        case (s.mode)
            pdm_pkg::pdm_normal: begin
                if (halt_done) begin
                    if (ctl[pdm_pkg::bit_standby_select]) begin
                        next_s.mode = pdm_pkg::pdm_standby;
                    end else begin
                        next_s.mode = pdm_pkg::pdm_sleep;
                    end
                end
            end
            pdm_pkg::pdm_sleep: begin
                if (interrupt_req) begin
                    next_s.mode = pdm_pkg::pdm_normal;
                end
            end
            pdm_pkg::pdm_standby: begin
                if (interrupt_req) begin
                    next_s.mode = pdm_pkg::pdm_wake;
                end
            end
            pdm_pkg::pdm_wake: begin
                // watchdog settling time ends wake
                if (watchdog_overflow) begin
                    next_s.mode = pdm_pkg::pdm_normal;
                end
            end
            default: begin
                next_s.mode = pdm_pkg::pdm_normal;
            end
        endcase

        next_s.cpu_halt = next_s.mode != pdm_pkg::pdm_normal;
        next_s.cg_halt = next_s.mode == pdm_pkg::pdm_standby || next_s.mode == pdm_pkg::pdm_wake;
        next_s.self_refresh = next_s.cg_halt;
        next_s.periph_en = !next_s.cg_halt;

        // state pins; wake still shows standby
        case (next_s.mode)
            pdm_pkg::pdm_sleep: next_s.pins = pdm_pkg::pins_sleep;
            pdm_pkg::pdm_standby: next_s.pins = pdm_pkg::pins_standby;
            pdm_pkg::pdm_wake: next_s.pins = pdm_pkg::pins_standby;
            default: next_s.pins = pdm_pkg::pins_normal;
        endcase

        next_s.wakeup_n = next_s.mode != pdm_pkg::pdm_wake;

        // timer clock; calendar-fed timer keeps going
        next_s.en[8] = !ctl[pdm_pkg::bit_timer_clock_stop]
            && (next_s.periph_en || (timer_on_calendar && calendar_start));
        next_s.cal_reg_en = !ctl[pdm_pkg::bit_calendar_clock_stop] && next_s.periph_en;
        // counter runs in standby when started
        next_s.cal_count_en = next_s.periph_en || calendar_start;
        next_s.en[7] = !ctl[pdm_pkg::bit_serial_clock_stop] && next_s.periph_en;
        // serial pins to reset while stopped
        next_s.serial_pins_reset = ctl[pdm_pkg::bit_serial_clock_stop];
        // bus clock stop bit gates in sleep only
        next_s.en[6] = !(ctl2[pdm_pkg::bit_bus_clock_stop_in_sleep]
            && next_s.mode == pdm_pkg::pdm_sleep) && next_s.periph_en;
        next_s.en[5] = !ctl2[pdm_pkg::bit_break_unit_clock_stop] && next_s.periph_en;
        next_s.en[4] = !ctl2[pdm_pkg::bit_dma_clock_stop] && next_s.periph_en;
        next_s.en[3] = !ctl2[pdm_pkg::bit_dac_clock_stop] && next_s.periph_en;
        next_s.en[2] = !ctl2[pdm_pkg::bit_adc_clock_stop] && next_s.periph_en;
        next_s.en[1] = !ctl2[pdm_pkg::bit_fifo_serial_clock_stop] && next_s.periph_en;
        next_s.en[0] = !ctl2[pdm_pkg::bit_infrared_clock_stop] && next_s.periph_en;
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    // pins high/high while in reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s.mode <= pdm_pkg::pdm_normal;
            s.cpu_halt <= 1'b0;
            s.cg_halt <= 1'b0;
            s.self_refresh <= 1'b0;
            s.pins <= pdm_pkg::pins_reset;
            s.wakeup_n <= 1'b1;
            s.en <= 9'h1ff;
            s.cal_reg_en <= 1'b1;
            s.cal_count_en <= 1'b1;
            s.serial_pins_reset <= 1'b0;
            s.periph_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // -------------------------------------------------------------
    // outputs, all from flip-flops
    // -------------------------------------------------------------
    assign cpu_halt = s.cpu_halt;
    assign clock_generator_halt = s.cg_halt;
    assign self_refresh = s.self_refresh;
    assign state_pin_high_bit = s.pins[1];
    assign state_pin_low_bit = s.pins[0];
    assign wakeup_n = s.wakeup_n;
    assign timer_clock_en = s.en[8];
    assign calendar_reg_clock_en = s.cal_reg_en;
    assign calendar_count_en = s.cal_count_en;
    assign serial_clock_en = s.en[7];
    assign serial_pins_reset = s.serial_pins_reset;
    assign peripheral_clock_en = s.periph_en;
    assign bus_clock_en = s.en[6];
    assign break_unit_clock_en = s.en[5];
    assign dma_clock_en = s.en[4];
    assign dac_clock_en = s.en[3];
    assign adc_clock_en = s.en[2];
    assign fifo_serial_clock_en = s.en[1];
    assign infrared_clock_en = s.en[0];
endmodule

// ---- rtl/pdm_pkg.sv ----
// power-down mode control package: register map, fields, states
package pdm_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [31:0] addr_standby_control = 32'hffff_ff82;
    localparam logic [31:0] addr_standby_control_secondary = 32'hffff_ff88;
    localparam logic [7:0] reset_standby_control = 8'h00;
    localparam logic [7:0] reset_standby_control_secondary = 8'h00;

    // -------------------------------------------------------------
    // primary register fields
    // -------------------------------------------------------------
    localparam int bit_standby_select = 7;
    localparam int bit_timer_clock_stop = 2;
    localparam int bit_calendar_clock_stop = 1;
    localparam int bit_serial_clock_stop = 0;
    localparam logic [7:0] mask_standby_control = 8'h87;

    // -------------------------------------------------------------
    // secondary register fields
    // -------------------------------------------------------------
    localparam int bit_bus_clock_stop_in_sleep = 7;
    localparam int bit_break_unit_clock_stop = 5;
    localparam int bit_dma_clock_stop = 4;
    localparam int bit_dac_clock_stop = 3;
    localparam int bit_adc_clock_stop = 2;
    localparam int bit_fifo_serial_clock_stop = 1;
    localparam int bit_infrared_clock_stop = 0;
    localparam logic [7:0] mask_standby_control_secondary = 8'hbf;

    // -------------------------------------------------------------
    // power state and state pin codes {high, low}
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        pdm_normal,
        pdm_sleep,
        pdm_standby,
        pdm_wake
    } pdm_state_t;

    localparam logic [1:0] pins_reset = 2'b11;
    localparam logic [1:0] pins_sleep = 2'b10;
    localparam logic [1:0] pins_standby = 2'b01;
    localparam logic [1:0] pins_normal = 2'b00;

endpackage

// ---- rtl/pdm_regs.sv ----
// power-down mode control register file
`timescale 1ns/100ps
module pdm_regs (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // register contents
    output logic [7:0] standby_control,
    output logic [7:0] standby_control_secondary
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] ctl2;
        logic [7:0] rdata;
    } pdm_regs_t;

    pdm_regs_t r;
    pdm_regs_t next_r;

    always_comb begin
        next_r = r;
        next_r.rdata = 8'h00;
        if (wr && addr == pdm_pkg::addr_standby_control) begin
            next_r.ctl = wdata & pdm_pkg::mask_standby_control;
        end
        if (wr && addr == pdm_pkg::addr_standby_control_secondary) begin
            next_r.ctl2 = wdata & pdm_pkg::mask_standby_control_secondary;
        end
        if (rd) begin
            if (addr == pdm_pkg::addr_standby_control) begin
                next_r.rdata = r.ctl & pdm_pkg::mask_standby_control;
            end else if (addr == pdm_pkg::addr_standby_control_secondary) begin
                next_r.rdata = r.ctl2 & pdm_pkg::mask_standby_control_secondary;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r.ctl <= pdm_pkg::reset_standby_control;
            r.ctl2 <= pdm_pkg::reset_standby_control_secondary;
            r.rdata <= 8'h00;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign standby_control = r.ctl;
    assign standby_control_secondary = r.ctl2;
endmodule

// ---- verif/pdm_properties.sv ----
// assertion checker for the power-down mode controller
`timescale 1ns/100ps
module pdm_properties (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    // cpu events and levels
    input wire logic halt_done,
    input wire logic interrupt_req,
    input wire logic watchdog_overflow,
    input wire logic calendar_start,
    // power state
    input wire logic cpu_halt,
    input wire logic clock_generator_halt,
    input wire logic self_refresh,
    input wire logic state_pin_high_bit,
    input wire logic state_pin_low_bit,
    input wire logic wakeup_n,
    // clock enables
    input wire logic timer_clock_en,
    input wire logic calendar_reg_clock_en,
    input wire logic calendar_count_en,
    input wire logic serial_clock_en,
    input wire logic serial_pins_reset,
    input wire logic peripheral_clock_en,
    input wire logic bus_clock_en,
    input wire logic break_unit_clock_en,
    input wire logic dma_clock_en,
    input wire logic dac_clock_en,
    input wire logic adc_clock_en,
    input wire logic fifo_serial_clock_en,
    input wire logic infrared_clock_en
);
    logic [7:0] sp, ss, sp_d, ss_d;
    logic [1:0] pins;
    assign pins = {state_pin_high_bit, state_pin_low_bit};
    // shadow copies; the delayed pair matches the extra enable stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {sp, ss, sp_d, ss_d} <= 32'h0000_0000;
        end else begin
            {sp_d, ss_d} <= {sp, ss};
            if (wr && addr == pdm_pkg::addr_standby_control) sp <= wdata & pdm_pkg::mask_standby_control;
            if (wr && addr == pdm_pkg::addr_standby_control_secondary) begin
                ss <= wdata & pdm_pkg::mask_standby_control_secondary;
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_sleep_entry: assert property (
        pins == 2'b00 && halt_done && !sp[7] |=> pins == 2'b10 && cpu_halt)
        else $error("halt did not enter sleep");
    a_standby_entry: assert property (
        pins == 2'b00 && halt_done && sp[7] |=> pins == 2'b01 && clock_generator_halt
        && self_refresh && !peripheral_clock_en) else $error("halt did not enter standby");
    a_sleep_exit: assert property (
        pins == 2'b10 && interrupt_req |=> pins == 2'b00 && !cpu_halt)
        else $error("sleep not ended by interrupt");
    a_wake_start: assert property (
        pins == 2'b01 && wakeup_n && interrupt_req |=> !wakeup_n && pins == 2'b01)
        else $error("wakeup not asserted");
    a_wake_hold: assert property (
        !wakeup_n && !watchdog_overflow |=> !wakeup_n)
        else $error("wakeup released early");
    a_wake_end: assert property (
        !wakeup_n && watchdog_overflow |=> wakeup_n && pins == 2'b00 && !cpu_halt)
        else $error("overflow did not restore normal");
    a_timer_gate: assert property (
        !clock_generator_halt |-> timer_clock_en == !sp_d[2])
        else $error("timer enable wrong");
    a_calendar_gate: assert property (
        clock_generator_halt ? calendar_count_en == calendar_start
        : calendar_reg_clock_en == !sp_d[1] && calendar_count_en) else $error("calendar enable wrong");
    a_serial_gate: assert property (
        !clock_generator_halt |-> serial_clock_en == !sp_d[0]
        && serial_pins_reset == sp_d[0]) else $error("serial enable wrong");
    a_module_gates: assert property (
        !clock_generator_halt |-> {break_unit_clock_en, dma_clock_en, dac_clock_en,
        adc_clock_en, fifo_serial_clock_en, infrared_clock_en} == ~ss_d[5:0]) else $error("module enable wrong");
    a_bus_sleep: assert property (
        !clock_generator_halt |-> bus_clock_en == !(ss_d[7] && pins == 2'b10))
        else $error("bus enable wrong");
    a_reserved_zero: assert property (
        rd && addr == pdm_pkg::addr_standby_control |=> rdata[6:3] == 4'h0)
        else $error("reserved bits read nonzero");
    // standby and wake stop every gated module clock except the timer and calendar counter, whatever the stop bits say
    a_standby_gates: assert property (
        clock_generator_halt |-> !serial_clock_en && !bus_clock_en && !calendar_reg_clock_en && !break_unit_clock_en
        && !dma_clock_en && !dac_clock_en && !adc_clock_en && !fifo_serial_clock_en && !infrared_clock_en)
        else $error("module clock running in standby");
endmodule
bind pdm_top pdm_properties pdm_properties_inst (.clock, .arst_n, .wr, .rd, .addr, .wdata, .rdata, .halt_done,
    .interrupt_req, .watchdog_overflow, .calendar_start, .cpu_halt, .clock_generator_halt, .self_refresh,
    .state_pin_high_bit, .state_pin_low_bit, .wakeup_n, .timer_clock_en, .calendar_reg_clock_en, .calendar_count_en,
    .serial_clock_en, .serial_pins_reset, .peripheral_clock_en, .bus_clock_en, .break_unit_clock_en, .dma_clock_en,
    .dac_clock_en, .adc_clock_en, .fifo_serial_clock_en, .infrared_clock_en);

// ---- verif/pdm_cpu_model.sv ----
// cpu core model: halt completion, interrupts, watchdog overflow
`timescale 1ns/100ps
module pdm_cpu_model (
    // clock
    input wire logic clock,
    // events toward the controller
    output logic halt_done,
    output logic interrupt_req,
    output logic watchdog_overflow
);
    initial {halt_done, interrupt_req, watchdog_overflow} = 3'b000;
    // gap lets the event come late, as a slow interrupt source would
    task automatic pulse(input int gap, input int which);
        repeat (gap + 1) @(posedge clock);
        case (which)
            0: halt_done <= 1'b1;
            1: interrupt_req <= 1'b1;
            default: watchdog_overflow <= 1'b1;
        endcase
        @(posedge clock);
        {halt_done, interrupt_req, watchdog_overflow} <= 3'b000;
        @(negedge clock);
    endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
    logic clock = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, calendar_start = 1'b0, timer_on_calendar = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic halt_done, interrupt_req, watchdog_overflow, cpu_halt, clock_generator_halt, self_refresh, wakeup_n;
    logic state_pin_high_bit, state_pin_low_bit, timer_clock_en, calendar_reg_clock_en, calendar_count_en;
    logic serial_clock_en, serial_pins_reset, peripheral_clock_en, bus_clock_en, break_unit_clock_en, dma_clock_en;
    logic dac_clock_en, adc_clock_en, fifo_serial_clock_en, infrared_clock_en;
    logic [1:0] pins;
    logic [5:0] mods;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    assign pins = {state_pin_high_bit, state_pin_low_bit};
    assign mods = {break_unit_clock_en, dma_clock_en, dac_clock_en, adc_clock_en,
        fifo_serial_clock_en, infrared_clock_en};
    always #2 clock = ~clock;
    pdm_cpu_model pdm_cpu_model_inst (.clock, .halt_done, .interrupt_req, .watchdog_overflow);
    pdm_top pdm_top_inst (.clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .halt_done, .interrupt_req,
        .watchdog_overflow, .calendar_start, .timer_on_calendar, .cpu_halt, .clock_generator_halt, .self_refresh,
        .state_pin_high_bit, .state_pin_low_bit, .wakeup_n, .timer_clock_en, .calendar_reg_clock_en,
        .calendar_count_en, .serial_clock_en, .serial_pins_reset, .peripheral_clock_en, .bus_clock_en,
        .break_unit_clock_en, .dma_clock_en, .dac_clock_en, .adc_clock_en, .fifo_serial_clock_en, .infrared_clock_en);
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        @(posedge clock);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
        @(posedge clock);
        {rd, addr} <= {1'b1, a};
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        `CHK(rdata, e)
    endtask
    // ---------------------------------------------
    // register access and module clock gating
    // ---------------------------------------------
    task automatic t_regs();
        // primary write keeps reserved bits zero; secondary write sets reserved bit 6, which reads back zero
        wr_reg(pdm_pkg::addr_standby_control, 8'h87);
        wr_reg(pdm_pkg::addr_standby_control_secondary, 8'h7f);
        rd_chk(pdm_pkg::addr_standby_control, 8'h87);
        rd_chk(pdm_pkg::addr_standby_control_secondary, 8'h3f);
        rd_chk(32'hffff_ff84, 8'h00);
        `CHK({timer_clock_en, calendar_reg_clock_en, serial_clock_en, serial_pins_reset}, 4'h1)
        `CHK({mods, bus_clock_en}, 7'h01)
        wr_reg(pdm_pkg::addr_standby_control, 8'h00);
        wr_reg(pdm_pkg::addr_standby_control_secondary, 8'h00);
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHK({mods, bus_clock_en, timer_clock_en}, 8'hff)
        `CHK({calendar_reg_clock_en, serial_clock_en, serial_pins_reset}, 3'h6)
    endtask
    // ---------------------------------------------
    // sleep with the bus clock gated
    // ---------------------------------------------
    task automatic t_sleep();
        wr_reg(pdm_pkg::addr_standby_control_secondary, 8'h80);
        pdm_cpu_model_inst.pulse(0, 0);
        `CHK({pins, cpu_halt, peripheral_clock_en, bus_clock_en}, 5'h16)
        pdm_cpu_model_inst.pulse(3, 1);
        `CHK({pins, cpu_halt, bus_clock_en}, 4'h1)
    endtask
    // ---------------------------------------------
    // standby, wake phase, then sleep again
    // ---------------------------------------------
    task automatic t_standby();
        @(posedge clock);
        {calendar_start, timer_on_calendar} <= 2'b11;
        wr_reg(pdm_pkg::addr_standby_control, 8'h80);
        pdm_cpu_model_inst.pulse(0, 0);
        `CHK({pins, clock_generator_halt, self_refresh, peripheral_clock_en}, 5'h0e)
        `CHK({cpu_halt, calendar_count_en, wakeup_n}, 3'h7)
        // calendar-fed timer keeps its clock, serial, bus and the six module clocks stop
        `CHK({timer_clock_en, serial_clock_en, bus_clock_en, mods}, 9'h100)
        pdm_cpu_model_inst.pulse(2, 1);
        `CHK({pins, wakeup_n}, 3'h2)
        pdm_cpu_model_inst.pulse(3, 2);
        `CHK({pins, wakeup_n, cpu_halt, clock_generator_halt}, 5'h04)
        wr_reg(pdm_pkg::addr_standby_control, 8'h00);
        pdm_cpu_model_inst.pulse(0, 0);
        `CHK(pins, 2'h2)
        pdm_cpu_model_inst.pulse(1, 1);
    endtask
    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // under a hundred cycles are expected; far beyond that means a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        `CHK({pins, wakeup_n}, 3'h7)
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        `CHK(pins, 2'h0)
        rd_chk(pdm_pkg::addr_standby_control, 8'h00);
        rd_chk(pdm_pkg::addr_standby_control_secondary, 8'h00);
        t_regs();
        t_sleep();
        t_standby();
        test_done();
    end
endmodule
